// >>> hw/bors_map.vh
`ifndef BORS_MAP_VH
`define BORS_MAP_VH

// Clock and start-up timing
`define BORS_CLK_HZ          50000000
`define BORS_PWRT_MS         96
`define BORS_MS_CYCLES       (`BORS_CLK_HZ / 1000)
`define BORS_OSC_PERIODS     1024
`define BORS_QUAL_CYCLES     4

// Register byte offsets
`define BORS_OFS_CTRL        8'h00
`define BORS_OFS_STATUS      8'h04
`define BORS_OFS_CORE_INT    8'h08
`define BORS_OFS_PERIPH_A    8'h0C
`define BORS_OFS_PERIPH_B    8'h10
`define BORS_OFS_PORT_DIR    8'h14
`define BORS_OFS_WAKE_PC     8'h18

// Control fields
`define BORS_CTRL_GID_BIT    0
`define BORS_CTRL_SLEEP_BIT  1

// Status fields
`define BORS_ST_RESET_BIT    0
`define BORS_ST_LOW_BIT      1
`define BORS_ST_FUSE_BIT     2
`define BORS_ST_SLEEP_BIT    3
`define BORS_ST_VEC_BIT      4
`define BORS_ST_FSM_LSB      8

// Reset values and interrupt vector
`define BORS_CTRL_RST        1'b1
`define BORS_PORT_DIR_RST    8'hFF
`define BORS_INT_VECTOR      16'h0020

`endif

// >>> hw/bors_sequencer.v
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bors_map.vh"

// Functional notes
// [R01] Fuse bit enables or disables brown-out reset
// [R02] Qualified supply-low asserts chip reset
// [R03] Dips shorter than qualify time filtered
// [R04] Reset held while supply-low stays active
// [R05] Release after longer of 96 ms, 1024 periods
// [R06] Dip during wait re-enters reset, timers cleared
// [R07] Timers restart only after supply-low clears
// [R08] Any device reset makes port pins inputs
// [R09] Wake loads vector if interrupts enabled, else PC+1
// [R10] Wake-up interrupt sets its status flag bits
// [R11] Supply-low synchronised, qualify count parameterised
// [R12] Fixed interval on own timebase, both must expire
module bors_sequencer #(
   parameter MS_CYCLES   = `BORS_MS_CYCLES,
   parameter PWRT_MS     = `BORS_PWRT_MS,
   parameter OSC_PERIODS = `BORS_OSC_PERIODS,
   parameter QUAL_CYCLES = `BORS_QUAL_CYCLES,
   parameter PORT_W      = 8
) (
   // Clock and reset
   input  wire              hclk,
   input  wire              hresetn,
   // AHB-Lite slave
   input  wire              hsel,
   input  wire [31:0]       haddr,
   input  wire [1:0]        htrans,
   input  wire              hwrite,
   input  wire [2:0]        hsize,
   input  wire [31:0]       hwdata,
   input  wire              hready,
   output wire              hreadyout,
   output wire              hresp,
   output reg  [31:0]       hrdata,
   // Supply monitor and configuration
   input  wire              brownout_trip_level,
   input  wire              brownout_enable_fuse,
   input  wire              ext_reset,
   // Interrupt sources and sleep PC
   input  wire [7:0]        core_int_req,
   input  wire [7:0]        periph_a_req,
   input  wire [7:0]        periph_b_req,
   input  wire [15:0]       sleep_pc,
   // Reset and wake outputs
   output wire              chip_reset,
   output wire [PORT_W-1:0] port_dir,
   output reg               wake_strobe,
   output reg               wake_to_vector,
   output reg  [15:0]       wake_pc
);

   localparam [2:0] ST_RUN  = 3'b001;
   localparam [2:0] ST_LOW  = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;

   localparam DIV_W  = $clog2(MS_CYCLES + 1);
   localparam MS_W   = $clog2(PWRT_MS + 1);
   localparam OSC_W  = $clog2(OSC_PERIODS + 1);
   localparam QUAL_W = $clog2(QUAL_CYCLES + 1);

   reg  [2:0]        state_r;
   reg  [2:0]        state_nxt;
   reg               low_meta_r;
   reg               low_sync_r;
   reg  [QUAL_W-1:0] qual_cnt_r;
   reg  [OSC_W-1:0]  osc_cnt_r;
   reg  [DIV_W-1:0]  ms_div_r;
   reg  [MS_W-1:0]   ms_cnt_r;
   reg               gid_r;
   reg               sleep_r;
   reg  [7:0]        core_int_r;
   reg  [7:0]        periph_a_r;
   reg  [7:0]        periph_b_r;
   reg  [PORT_W-1:0] port_dir_r;
   reg               wr_pend_r;
   reg  [7:0]        wr_addr_r;

   wire              brown_en;
   wire              qualified;
   wire              osc_done;
   wire              ms_done;
   wire              ms_tick;
   wire              addr_ok;
   wire              any_req;
   wire [7:0]        ofs;
   wire [31:0]       status_word;
   wire              wr_ctrl;
   wire              wr_core;
   wire              wr_pa;
   wire              wr_pb;
   wire              wr_dir;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // [R01] fuse gate
   assign brown_en  = brownout_enable_fuse;

   // [R11] supply-low synchroniser
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_meta_r <= 1'b0;
         low_sync_r <= 1'b0;
      end else begin
         low_meta_r <= brownout_trip_level;
         low_sync_r <= low_meta_r;
      end
   end

   // [R03] short dip filter
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qual_cnt_r <= {QUAL_W{1'b0}};
      end else if (!low_sync_r || !brown_en) begin
         qual_cnt_r <= {QUAL_W{1'b0}};
      end else if (qual_cnt_r != QUAL_CYCLES[QUAL_W-1:0]) begin
         qual_cnt_r <= qual_cnt_r + 1'b1;
      end
   end

   // [R11] qualify count reached
   assign qualified = brown_en && (qual_cnt_r == QUAL_CYCLES[QUAL_W-1:0]);

   // [R12] independent millisecond timebase
   assign ms_tick = (ms_div_r == MS_CYCLES[DIV_W-1:0] - 1'b1);
   assign ms_done = (ms_cnt_r == PWRT_MS[MS_W-1:0]);
   assign osc_done = (osc_cnt_r == OSC_PERIODS[OSC_W-1:0]);

   // [R06] timers cleared outside the wait
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_cnt_r <= {OSC_W{1'b0}};
         ms_div_r  <= {DIV_W{1'b0}};
         ms_cnt_r  <= {MS_W{1'b0}};
      end else if (state_r != ST_WAIT) begin
         osc_cnt_r <= {OSC_W{1'b0}};
         ms_div_r  <= {DIV_W{1'b0}};
         ms_cnt_r  <= {MS_W{1'b0}};
      end else begin
         // [R05] both timers run together
         if (!osc_done)
            osc_cnt_r <= osc_cnt_r + 1'b1;
         if (!ms_done) begin
            if (ms_tick) begin
               ms_div_r <= {DIV_W{1'b0}};
               ms_cnt_r <= ms_cnt_r + 1'b1;
            end else begin
               ms_div_r <= ms_div_r + 1'b1;
            end
         end
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            // [R02] enter brown-out reset
            if (qualified)
               state_nxt = ST_LOW;
         end
         ST_LOW: begin
            // [R04] hold while supply low
            // [R07] restart only after clearing
            if (!low_sync_r || !brown_en)
               state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            // [R06] dip during start-up wait
            if (brown_en && low_sync_r)
               state_nxt = ST_LOW;
            // [R05] longer of both delays
            else if (osc_done && ms_done)
               state_nxt = ST_RUN;
         end
         default: state_nxt = ST_WAIT;
      endcase
   end

   // Power-on counts as a start-up wait too
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state_r <= ST_WAIT;
      else
         state_r <= state_nxt;
   end

   // Taken straight from the RUN flop; a decode of
   // several state bits could glitch the reset line
   assign chip_reset = ~state_r[0];

   // Bus write capture; writes land in the data phase
   assign addr_ok = hsel && hready && htrans[1];
   assign ofs     = {haddr[7:2], 2'b00};

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
         wr_addr_r <= ofs;
      end
   end

   assign wr_ctrl = wr_pend_r && (wr_addr_r == `BORS_OFS_CTRL);
   assign wr_core = wr_pend_r && (wr_addr_r == `BORS_OFS_CORE_INT);
   assign wr_pa   = wr_pend_r && (wr_addr_r == `BORS_OFS_PERIPH_A);
   assign wr_pb   = wr_pend_r && (wr_addr_r == `BORS_OFS_PERIPH_B);
   assign wr_dir  = wr_pend_r && (wr_addr_r == `BORS_OFS_PORT_DIR);
   assign any_req = |{core_int_req, periph_a_req, periph_b_req};

   // Flags: set wins over write-one-to-clear
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               core_int_r[gi] <= 1'b0;
               periph_a_r[gi] <= 1'b0;
               periph_b_r[gi] <= 1'b0;
            end else begin
               // [R10] wake source flags set
               core_int_r[gi] <= core_int_req[gi] |
                                 (core_int_r[gi] & ~(wr_core & hwdata[gi]));
               periph_a_r[gi] <= periph_a_req[gi] |
                                 (periph_a_r[gi] & ~(wr_pa & hwdata[gi]));
               periph_b_r[gi] <= periph_b_req[gi] |
                                 (periph_b_r[gi] & ~(wr_pb & hwdata[gi]));
            end
         end
      end
   endgenerate

   // Control, sleep and wake
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gid_r          <= `BORS_CTRL_RST;
         sleep_r        <= 1'b0;
         wake_strobe    <= 1'b0;
         wake_to_vector <= 1'b0;
         wake_pc        <= 16'h0000;
      end else begin
         wake_strobe <= 1'b0;
         if (chip_reset || ext_reset) begin
            gid_r   <= `BORS_CTRL_RST;
            sleep_r <= 1'b0;
         end else if (sleep_r && any_req) begin
            sleep_r     <= 1'b0;
            wake_strobe <= 1'b1;
            // [R09] vector or next address
            wake_to_vector <= ~gid_r;
            wake_pc        <= gid_r ? sleep_pc + 16'h0001 : `BORS_INT_VECTOR;
         end else if (wr_ctrl) begin
            gid_r   <= hwdata[`BORS_CTRL_GID_BIT];
            sleep_r <= hwdata[`BORS_CTRL_SLEEP_BIT];
         end
      end
   end

   // Direction: 1 means input
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         port_dir_r <= {PORT_W{1'b1}};
      // [R08] any reset forces inputs
      else if (chip_reset || ext_reset)
         port_dir_r <= {PORT_W{1'b1}};
      else if (wr_dir)
         port_dir_r <= hwdata[PORT_W-1:0];
   end

   assign port_dir = port_dir_r;

   assign status_word = {21'h000000, state_r, 3'b000, wake_to_vector, sleep_r,
                         brown_en, low_sync_r, chip_reset};

   // Read data registered at the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_ok && !hwrite) begin
         if (haddr[31:8] != 24'h000000)
            hrdata <= 32'h00000000;
         else
            case (ofs)
               `BORS_OFS_CTRL:     hrdata <= {30'h00000000, sleep_r, gid_r};
               `BORS_OFS_STATUS:   hrdata <= status_word;
               `BORS_OFS_CORE_INT: hrdata <= {24'h000000, core_int_r};
               `BORS_OFS_PERIPH_A: hrdata <= {24'h000000, periph_a_r};
               `BORS_OFS_PERIPH_B: hrdata <= {24'h000000, periph_b_r};
               `BORS_OFS_PORT_DIR: hrdata <= {{(32-PORT_W){1'b0}}, port_dir_r};
               `BORS_OFS_WAKE_PC:  hrdata <= {16'h0000, wake_pc};
               default:            hrdata <= 32'h00000000;
            endcase
      end
   end

endmodule

// >>> bench/bors_props.sv
`timescale 1ns/1ps
module bors_props #(
   parameter OSC_PERIODS = 1024
) (
   // Clock and reset
   input wire        hclk,
   input wire        hresetn,
   // Bus response
   input wire        hreadyout,
   input wire        hresp,
   // Supply and wake inputs
   input wire        brownout_trip_level,
   input wire        brownout_enable_fuse,
   input wire        ext_reset,
   input wire [15:0] sleep_pc,
   // Watched outputs
   input wire        chip_reset,
   input wire [7:0]  port_dir,
   input wire        wake_strobe,
   input wire        wake_to_vector,
   input wire [15:0] wake_pc
);
   // Held-reset cycles since the supply last dipped; a dip restarts it
   logic [15:0] quiet_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         quiet_r <= 16'h0000;
      else if (brownout_trip_level || !chip_reset)
         quiet_r <= 16'h0000;
      // Saturates so a full-length start-up wait cannot wrap it
      else if (quiet_r != 16'hFFFF)
         quiet_r <= quiet_r + 16'h0001;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   release_wait_a: assert property (
      $fell(chip_reset) && !$past(ext_reset) |-> quiet_r >= OSC_PERIODS - 1)
      else $error("reset released early");
   qual_trip_a: assert property (
      (brownout_trip_level && brownout_enable_fuse)[*8] |-> ##[0:1] chip_reset)
      else $error("no reset on supply low");
   hold_low_a: assert property (
      (chip_reset && brownout_trip_level && brownout_enable_fuse)[*3] |=> chip_reset)
      else $error("reset dropped while low");
   fuse_off_a: assert property (
      !brownout_enable_fuse && !ext_reset && !chip_reset |=> !chip_reset)
      else $error("reset with fuse clear");
   port_input_a: assert property (
      chip_reset || ext_reset |=> port_dir == 8'hFF)
      else $error("pins not inputs in reset");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   wake_pulse_a: assert property (wake_strobe |=> !wake_strobe)
      else $error("wake strobe too long");
   wake_next_a: assert property (
      wake_strobe && !wake_to_vector |-> wake_pc == $past(sleep_pc) + 16'h0001)
      else $error("wake pc not next");
   wake_vector_a: assert property (
      wake_strobe && wake_to_vector |-> wake_pc == 16'h0020)
      else $error("wake pc not vector");
   wake_gate_a: assert property (chip_reset |=> !wake_strobe)
      else $error("wake during reset");
endmodule

// >>> bench/bors_tb.sv
`timescale 1ns/1ps
module testbench;
   localparam OSC = 64;
   logic        hclk, hresetn, hsel, hwrite, trip, fuse, ext_rst, hrdy, resp, cr, wk, wk_vec;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0]  c_req, a_req, b_req, pdir;
   logic [15:0] wpc;
   int          n_mismatch, checks_done, n;
   bors_sequencer #(.MS_CYCLES(10), .PWRT_MS(2), .OSC_PERIODS(OSC)) u_bors_sequencer (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
      .hresp(resp), .hrdata(hrdata), .brownout_trip_level(trip),
      .brownout_enable_fuse(fuse), .ext_reset(ext_rst), .core_int_req(c_req),
      .periph_a_req(a_req), .periph_b_req(b_req), .sleep_pc(16'h1234), .chip_reset(cr),
      .port_dir(pdir), .wake_strobe(wk), .wake_to_vector(wk_vec), .wake_pc(wpc));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task timeout;
      n_mismatch++;
      give_verdict;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask
   // Edge with hready high, bounded
   task rdy;
      int k;
      k = 0;
      @(posedge hclk);
      while (hrdy !== 1'b1) begin
         k++;
         if (k > 50) timeout;
         @(posedge hclk);
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      rd = hrdata;
   endtask
   task wait_cr(input logic v);
      n = 0;
      while (cr !== v) begin
         @(posedge hclk);
         n++;
         if (n > 5000) timeout;
      end
   endtask
   task pulse(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
      @(posedge hclk);
      c_req <= c;
      a_req <= a;
      b_req <= b;
      @(posedge hclk);
      c_req <= 8'h00;
      a_req <= 8'h00;
      b_req <= 8'h00;
      @(posedge hclk);
   endtask
   task s_power;
      check(pdir, 32'hFF);
      wait_cr(1'b0);
      check(n >= OSC - 1 && n <= OSC + 4, 32'h1);
      ahb(1'b0, 32'h00, 32'h0);
      check(rd[1:0], 32'h1);
      ahb(1'b0, 32'h40, 32'h0);
      check(rd, 32'h0);
   endtask
   task s_brown;
      @(posedge hclk);
      trip <= 1'b1;
      wait_cr(1'b1);
      check(n <= 9, 32'h1);
      cyc(20);
      check(cr, 32'h1);
      trip <= 1'b0;
      cyc(30);
      check(cr, 32'h1);
      trip <= 1'b1;
      cyc(3);
      trip <= 1'b0;
      wait_cr(1'b0);
      check(n >= OSC && n <= OSC + 8, 32'h1);
   endtask
   task s_filter;
      @(posedge hclk);
      trip <= 1'b1;
      @(posedge hclk);
      trip <= 1'b0;
      cyc(10);
      check(cr, 32'h0);
      fuse <= 1'b0;
      trip <= 1'b1;
      cyc(20);
      check(cr, 32'h0);
      ahb(1'b0, 32'h04, 32'h0);
      check(rd[2:0], 32'h2);
      trip <= 1'b0;
      fuse <= 1'b1;
   endtask
   task s_wake;
      ahb(1'b1, 32'h14, 32'h0);
      ahb(1'b0, 32'h14, 32'h0);
      check(rd[7:0], 32'h0);
      ext_rst <= 1'b1;
      @(posedge hclk);
      ext_rst <= 1'b0;
      @(posedge hclk);
      check(pdir, 32'hFF);
      wait_cr(1'b0);
      pulse(8'h00, 8'h81, 8'h00);
      ahb(1'b0, 32'h0C, 32'h0);
      check(rd[7:0], 32'h81);
      ahb(1'b1, 32'h00, 32'h3);
      pulse(8'h04, 8'h00, 8'h00);
      check({wk, wk_vec, wpc}, {2'h2, 16'h1235});
      ahb(1'b0, 32'h08, 32'h0);
      check(rd[7:0], 32'h04);
      ahb(1'b1, 32'h08, 32'h4);
      ahb(1'b0, 32'h08, 32'h0);
      check(rd[7:0], 32'h0);
      ahb(1'b1, 32'h00, 32'h2);
      pulse(8'h00, 8'h00, 8'h10);
      check({wk, wk_vec, wpc}, {2'h3, 16'h0020});
      ahb(1'b0, 32'h10, 32'h0);
      check(rd[7:0], 32'h10);
      ahb(1'b0, 32'h18, 32'h0);
      check(rd, 32'h00000020);
   endtask
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      {hresetn, hsel, hwrite, trip, ext_rst, htrans, haddr, hwdata} = '0;
      {c_req, a_req, b_req, n_mismatch, checks_done} = '0;
      fuse = 1'b1;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      s_power;
      s_brown;
      s_filter;
      s_wake;
      give_verdict;
   end
endmodule
bind bors_sequencer bors_props #(.OSC_PERIODS(OSC_PERIODS)) u_bors_props (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .brownout_trip_level(brownout_trip_level), .brownout_enable_fuse(brownout_enable_fuse),
   .ext_reset(ext_reset), .sleep_pc(sleep_pc), .chip_reset(chip_reset),
   .port_dir(port_dir), .wake_strobe(wake_strobe), .wake_to_vector(wake_to_vector),
   .wake_pc(wake_pc));
